// >>> logic/l5g_consts.vh
// Constants for the code and symbol generator
//
// Overview of operation
// - Secondary start: load vector directly, or load ones and step given count.
// - Shift from stage 1 toward 13; stage 13 is output and rightmost.
// - Primary register reloads all ones after its 8190th state.
// - Secondary runs full 8191 states, no short cycle, restarting at completion.
// - Primary forced to all ones at each 1 ms epoch, 10230 chips.
// - Secondary free-runs, reloads its start vector at each 1 ms epoch.
// - Advance count above 6152 lets a third secondary run begin.
// - Quadrature code XORed per millisecond with 20-bit overlay, aligned to bits.
// - Nav bits always rate one half encoded, 100 symbols per second.
// - Overlaid symbols XORed with in-phase spreading chips.
// - Encoder constraint length 7: six delays plus current bit.
// - First encoder output fills first half of each 20 ms bit.
// - Encoder never flushed; carries last six bits across messages.
// - Message first symbol starts on every fourth epoch from week start.
// - Each symbol XORed with 10-bit overlay 0000110101 from its start.
// - Week seconds count runs 0 to 403199 over epochs, wraps weekly.
// - Message time field is upper 17 bits of next message start count.
// - Bits above week seconds count hold the current week number.
// - 10.23 Mbps chip rate, primary and secondary feedback taps as given.
`ifndef L5G_CONSTS_VH
`define L5G_CONSTS_VH

// ==========================================================
// Shift register generators
`define L5G_LFSR_W       13
`define L5G_ONES         13'h1fff
`define L5G_PRI_TAPS     13'h1b00
`define L5G_SEC_TAPS     13'h18ed
`define L5G_PRI_LAST     13'h1ffd

// ==========================================================
// Overlay codes, first bit in the most significant position
`define L5G_NH10         10'h035
`define L5G_NH20         20'h04d4e

// ==========================================================
// Convolutional encoder
`define L5G_G1_POLY      7'h79
`define L5G_G2_POLY      7'h5b

// ==========================================================
// Millisecond and time counting
`define L5G_MS_LAST      5'h13
`define L5G_MS_HALF      5'h0a
`define L5G_MS_RST       5'h13
`define L5G_TOW_W        19
`define L5G_TOW_LAST     19'h626ff
`define L5G_MSG_TOW_W    17
`define L5G_MSG_TOW_LAST 17'h189bf

`endif

// >>> logic/l5g_skid_buf.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module l5g_skid_buf #(
  parameter W = 1
)(
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_sys_rst,
  // Filling side
  input  wire         i_in_valid,
  input  wire [W-1:0] i_in_data,
  output reg          o_in_ready,
  // Draining side
  output wire         o_out_valid,
  output wire [W-1:0] o_out_data,
  input  wire         i_out_ready
);

  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg [1:0]   count;
  reg [1:0]   next_count;
  wire        push;
  wire        pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_valid = (count != 2'h0);
  assign o_out_data  = slot0;

  always @*
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 2'h1;
    else if (pop && !push)
      next_count = count - 2'h1;
  end

  // ==========================================================
  // Slot 0 is always the head
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      slot0      <= {W{1'b0}};
      slot1      <= {W{1'b0}};
      count      <= 2'h0;
      o_in_ready <= 1'b1;
    end
    else
    begin
      if (pop)
      begin
        slot0 <= (count == 2'h2) ? slot1 : i_in_data;
        if (push && count == 2'h2)
          slot1 <= i_in_data;
      end
      else if (push)
      begin
        if (count == 2'h0)
          slot0 <= i_in_data;
        else
          slot1 <= i_in_data;
      end
      count      <= next_count;
      o_in_ready <= (next_count != 2'h2);
    end
  end

endmodule

// >>> logic/l5g_code_gen.v
// Spreading code, symbol stream and time counting for the code and symbol generator
`timescale 1ns/100ps
`include "l5g_consts.vh"
module l5g_code_gen #(
  parameter WEEK_W = 13
)(
  // Clock and reset
  input  wire                      i_clk,
  input  wire                      i_sys_rst,
  // Chip timing strobes from the chip clock logic
  input  wire                      i_chip_stb,
  input  wire                      i_ms_epoch,
  input  wire                      i_x1_epoch,
  // Time preset
  input  wire                      i_time_load,
  input  wire [`L5G_TOW_W-1:0]     i_tow_init,
  input  wire [WEEK_W-1:0]         i_week_init,
  // Secondary start preparation
  input  wire                      i_prep_stb,
  input  wire                      i_prep_advance,
  input  wire [12:0]               i_start_vec_i,
  input  wire [12:0]               i_start_vec_q,
  input  wire [12:0]               i_adv_i,
  input  wire [12:0]               i_adv_q,
  // Navigation bit train
  input  wire                      i_nav_bit,
  input  wire                      i_nav_valid,
  output wire                      o_nav_ready,
  // Modulator side
  output reg                       o_inphase_spread_code,
  output reg                       o_quadrature_spread_code,
  output reg                       o_chip_valid,
  output reg                       o_symbol_start,
  output reg                       o_primary_epoch,
  // Status and time
  output reg                       o_prep_busy,
  output reg                       o_nav_underrun,
  output reg                       o_msg_start,
  output reg  [`L5G_TOW_W-1:0]     o_tow_count,
  output reg  [WEEK_W-1:0]         o_week_num,
  output reg  [`L5G_MSG_TOW_W-1:0] o_msg_tow
);

  // ==========================================================
  // Functions
  // Bit k of a register holds stage k+1
  function [12:0] lfsr_step;
    input [12:0] state;
    input [12:0] taps;
    begin
      lfsr_step = {state[11:0], ^(state & taps)};
    end
  endfunction

  // Printed vector has stage 13 rightmost, stage 1 leftmost
  function [12:0] vec_to_reg;
    input [12:0] vec;
    integer k;
    begin
      for (k = 0; k < 13; k = k + 1)
        vec_to_reg[k] = vec[12-k];
    end
  endfunction

  function enc_out;
    input       bit_in;
    input [5:0] delays;
    input [6:0] poly;
    begin
      enc_out = ^({bit_in, delays[0], delays[1], delays[2],
                   delays[3], delays[4], delays[5]} & poly);
    end
  endfunction

  // ==========================================================
  // Strobes
  wire chip_tick;
  wire ms_tick;
  wire x1_tick;

  assign chip_tick = i_chip_stb;
  assign ms_tick   = i_chip_stb && i_ms_epoch;
  assign x1_tick   = i_chip_stb && i_x1_epoch;

  // ==========================================================
  // Primary generator
  reg  [12:0] primary_code_lfsr;
  reg  [12:0] pri_cnt;
  wire        pri_last;

  assign pri_last = (pri_cnt == `L5G_PRI_LAST);

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      primary_code_lfsr <= `L5G_ONES;
      pri_cnt           <= 13'h0000;
    end
    else if (chip_tick)
    begin
      if (ms_tick)
      begin
        primary_code_lfsr <= `L5G_ONES;
        pri_cnt           <= 13'h0000;
      end
      else if (pri_last)
      begin
        primary_code_lfsr <= `L5G_ONES;
        pri_cnt           <= 13'h0000;
      end
      else
      begin
        primary_code_lfsr <= lfsr_step(primary_code_lfsr, `L5G_PRI_TAPS);
        pri_cnt           <= pri_cnt + 13'h0001;
      end
    end
  end

  // ==========================================================
  // Secondary generators: lane 0 in-phase, lane 1 quadrature
  wire [25:0] vec_bus;
  wire [25:0] adv_bus;
  wire [1:0]  lane_busy;
  wire [1:0]  sec_out;
  wire        prep_take;

  assign vec_bus   = {i_start_vec_q, i_start_vec_i};
  assign adv_bus   = {i_adv_q, i_adv_i};
  assign prep_take = i_prep_stb && !(|lane_busy);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : sec_lane
      reg [12:0] secondary_code_lfsr;
      reg [12:0] secondary_start_state;
      reg [12:0] shadow;
      reg [12:0] adv_left;
      reg        busy;

      assign lane_busy[g] = busy;
      assign sec_out[g]   = secondary_code_lfsr[12];

      always @(posedge i_clk)
      begin
        if (i_sys_rst)
        begin
          secondary_code_lfsr   <= `L5G_ONES;
          secondary_start_state <= `L5G_ONES;
          shadow                <= `L5G_ONES;
          adv_left              <= 13'h0000;
          busy                  <= 1'b0;
        end
        else
        begin
          if (prep_take)
          begin
            if (i_prep_advance)
            begin
              shadow   <= `L5G_ONES;
              adv_left <= adv_bus[g*13 +: 13];
              busy     <= 1'b1;
            end
            else
              secondary_start_state <= vec_to_reg(vec_bus[g*13 +: 13]);
          end
          else if (busy)
          begin
            if (adv_left == 13'h0000)
            begin
              secondary_start_state <= shadow;
              busy                  <= 1'b0;
            end
            else
            begin
              shadow   <= lfsr_step(shadow, `L5G_SEC_TAPS);
              adv_left <= adv_left - 13'h0001;
            end
          end
          if (chip_tick)
          begin
            // Natural 8191 period restarts by itself; a start state late in the
            // sequence therefore wraps and begins a third run before the epoch
            if (ms_tick)
              secondary_code_lfsr <= secondary_start_state;
            else
              secondary_code_lfsr <= lfsr_step(secondary_code_lfsr,
                                               `L5G_SEC_TAPS);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Millisecond position within the 20 ms bit
  reg [4:0] ms_cnt;
  reg [4:0] next_ms;
  wire      bit_tick;

  always @*
  begin
    next_ms = ms_cnt;
    if (ms_tick)
    begin
      if (i_x1_epoch || ms_cnt == `L5G_MS_LAST)
        next_ms = 5'h00;
      else
        next_ms = ms_cnt + 5'h01;
    end
  end

  assign bit_tick = ms_tick && (next_ms == 5'h00);

  // ==========================================================
  // Navigation bit buffer and encoder
  wire       buf_valid;
  wire       buf_bit;
  reg  [5:0] enc_delay;
  reg        sym_first;
  reg        sym_second;
  wire       cur_bit;

  l5g_skid_buf #(
    .W (1)
  ) u_nav_buf (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_nav_valid),
    .i_in_data   (i_nav_bit),
    .o_in_ready  (o_nav_ready),
    .o_out_valid (buf_valid),
    .o_out_data  (buf_bit),
    .i_out_ready (bit_tick)
  );

  // Starved buffer sends zero bits so the symbol clock never slips
  assign cur_bit = buf_valid ? buf_bit : 1'b0;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ms_cnt     <= `L5G_MS_RST;
      enc_delay  <= 6'h00;
      sym_first  <= 1'b0;
      sym_second <= 1'b0;
    end
    else
    begin
      ms_cnt <= next_ms;
      if (bit_tick)
      begin
        sym_first  <= enc_out(cur_bit, enc_delay, `L5G_G1_POLY);
        sym_second <= enc_out(cur_bit, enc_delay, `L5G_G2_POLY);
        enc_delay  <= {enc_delay[4:0], cur_bit};
      end
    end
  end

  // ==========================================================
  // Symbol selection and overlays
  reg       cur_sym;
  reg [3:0] nh10_idx;
  reg       nh10_bit;
  reg       nh20_bit;
  reg       next_i;
  reg       next_q;

  always @*
  begin
    nh10_idx = 4'h0;
    cur_sym  = sym_first;
    if (ms_cnt >= `L5G_MS_HALF)
    begin
      cur_sym  = sym_second;
      nh10_idx = ms_cnt[3:0] - 4'ha;
    end
    else
      nh10_idx = ms_cnt[3:0];
    nh10_bit = |((`L5G_NH10 >> (4'h9 - nh10_idx)) & 10'h001);
    nh20_bit = |((`L5G_NH20 >> (5'h13 - ms_cnt)) & 20'h00001);
    next_i   = primary_code_lfsr[12] ^ sec_out[0] ^ cur_sym ^ nh10_bit;
    next_q   = primary_code_lfsr[12] ^ sec_out[1] ^ nh20_bit;
  end

  // ==========================================================
  // Chip outputs, two clocks after the strobe edge
  reg chip_d;
  reg sym_d;
  reg pri_ep_d;

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      chip_d                   <= 1'b0;
      sym_d                    <= 1'b0;
      pri_ep_d                 <= 1'b0;
      o_chip_valid             <= 1'b0;
      o_symbol_start           <= 1'b0;
      o_primary_epoch          <= 1'b0;
      o_inphase_spread_code    <= 1'b0;
      o_quadrature_spread_code <= 1'b0;
      o_nav_underrun           <= 1'b0;
      o_prep_busy              <= 1'b0;
    end
    else
    begin
      chip_d          <= chip_tick;
      sym_d           <= ms_tick && (next_ms == 5'h00 || next_ms == `L5G_MS_HALF);
      pri_ep_d        <= chip_tick && (ms_tick || pri_last);
      o_chip_valid    <= chip_d;
      o_symbol_start  <= sym_d;
      o_primary_epoch <= pri_ep_d;
      if (chip_d)
      begin
        o_inphase_spread_code    <= next_i;
        o_quadrature_spread_code <= next_q;
      end
      o_nav_underrun <= bit_tick && !buf_valid;
      o_prep_busy    <= (|lane_busy) || (prep_take && i_prep_advance);
    end
  end

  // ==========================================================
  // Week seconds count and week number
  reg  [`L5G_TOW_W-1:0]     next_tow;
  reg                       tow_wrap;
  wire [`L5G_MSG_TOW_W-1:0] tow_upper;

  always @*
  begin
    tow_wrap = (o_tow_count == `L5G_TOW_LAST);
    if (tow_wrap)
      next_tow = {`L5G_TOW_W{1'b0}};
    else
      next_tow = o_tow_count + 19'h00001;
  end

  assign tow_upper = next_tow[`L5G_TOW_W-1:2];

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_tow_count <= {`L5G_TOW_W{1'b0}};
      o_week_num  <= {WEEK_W{1'b0}};
      o_msg_tow   <= {`L5G_MSG_TOW_W{1'b0}};
      o_msg_start <= 1'b0;
    end
    else
    begin
      o_msg_start <= 1'b0;
      if (i_time_load)
      begin
        o_tow_count <= i_tow_init;
        o_week_num  <= i_week_init;
      end
      else if (x1_tick)
      begin
        o_tow_count <= next_tow;
        if (tow_wrap)
          o_week_num <= o_week_num + {{(WEEK_W-1){1'b0}}, 1'b1};
        if (next_tow[1:0] == 2'h0)
        begin
          o_msg_start <= 1'b1;
          if (tow_upper == `L5G_MSG_TOW_LAST)
            o_msg_tow <= {`L5G_MSG_TOW_W{1'b0}};
          else
            o_msg_tow <= tow_upper + 17'h00001;
        end
      end
    end
  end

endmodule

// >>> tb/l5g_code_gen_monitor.sv
// Concurrent checks on the ports of the code and symbol generator
`timescale 1ns/100ps
`include "l5g_consts.vh"
module l5g_code_gen_monitor #(
  parameter WEEK_W = 13
)(
  // Clock, reset and strobes
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_chip_stb,
  input wire        i_ms_epoch,
  input wire        i_x1_epoch,
  input wire        i_time_load,
  // Chip stream
  input wire        o_quadrature_spread_code,
  input wire        o_chip_valid,
  input wire        o_symbol_start,
  input wire        o_primary_epoch,
  // Status and time
  input wire        o_prep_busy,
  input wire        o_msg_start,
  input wire [18:0] o_tow_count,
  input wire [WEEK_W-1:0] o_week_num,
  input wire [16:0] o_msg_tow
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // Epoch tick of the time count
  sequence s_x1;
    i_chip_stb && i_x1_epoch && !i_time_load;
  endsequence
  sequence s_msg_due;
    s_x1 ##0 (o_tow_count[1:0] == 2'h3);
  endsequence
  AST_CHIP_LAT: assert property (i_chip_stb |-> ##2 o_chip_valid)
    else $error("chip strobe not answered two cycles later");
  AST_CHIP_SRC: assert property (o_chip_valid |-> $past(i_chip_stb, 2))
    else $error("chip valid without a strobe");
  AST_EPOCH: assert property (i_chip_stb && i_ms_epoch |-> ##2 o_primary_epoch)
    else $error("millisecond epoch did not restart primary code");
  AST_Q_HOLD: assert property ($changed(o_quadrature_spread_code) |-> o_chip_valid)
    else $error("quadrature chip changed between chips");
  AST_SYM: assert property (o_symbol_start |-> o_chip_valid)
    else $error("symbol start off a chip");
  AST_TOW_RANGE: assert property (o_tow_count <= `L5G_TOW_LAST)
    else $error("week seconds count out of range");
  AST_TOW_STEP: assert property (s_x1 |=> o_tow_count == ($past(o_tow_count)
    == `L5G_TOW_LAST ? 19'h0 : $past(o_tow_count) + 19'h1))
    else $error("week seconds count step wrong");
  AST_WEEK: assert property (s_x1 ##0 (o_tow_count == `L5G_TOW_LAST)
    |=> o_week_num == $past(o_week_num) + 1'b1)
    else $error("week number not advanced");
  AST_MSG: assert property (s_msg_due |=> o_msg_start ##0 o_msg_tow == (o_tow_count[18:2]
    == `L5G_MSG_TOW_LAST ? 17'h0 : o_tow_count[18:2] + 17'h1))
    else $error("message start or message time wrong");
  AST_MSG_SRC: assert property (o_msg_start |-> $past(i_chip_stb && i_x1_epoch))
    else $error("message start without epoch");
  // ==========================================================
  // Cycles spent in advance preparation
  reg [13:0] prep_cycles;
  always @(posedge i_clk)
  begin
    if (i_sys_rst || !o_prep_busy)
      prep_cycles <= 14'h0000;
    else if (prep_cycles != 14'h3fff)
      prep_cycles <= prep_cycles + 14'h0001;
  end
  AST_PREP: assert property (prep_cycles <= 14'h2008)
    else $error("preparation never finished");
endmodule
bind l5g_code_gen l5g_code_gen_monitor #(.WEEK_W(WEEK_W)) l5g_code_gen_monitor_inst (
  .i_clk, .i_sys_rst, .i_chip_stb, .i_ms_epoch, .i_x1_epoch, .i_time_load,
  .o_quadrature_spread_code, .o_chip_valid, .o_symbol_start, .o_primary_epoch,
  .o_prep_busy, .o_msg_start, .o_tow_count, .o_week_num, .o_msg_tow);

// >>> tb/l5g_rx_replica.sv
// Receiver side model that counts chips and symbol starts
`timescale 1ns/100ps
module l5g_rx_replica (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Chip stream
  input  wire        i_chip_valid,
  input  wire        i_sym_start,
  // Counts
  output reg  [15:0] o_n_chip,
  output reg  [15:0] o_n_sym
);
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_n_chip <= 16'h0;
      o_n_sym  <= 16'h0;
    end
    else
    begin
      o_n_chip <= o_n_chip + {15'h0, i_chip_valid};
      o_n_sym  <= o_n_sym + {15'h0, i_sym_start && i_chip_valid};
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking testbench for the code and symbol generator
`timescale 1ns/100ps
`include "l5g_consts.vh"
module tb;
  localparam [9:0]  NH10 = `L5G_NH10;
  localparam [19:0] NH20 = `L5G_NH20;
  reg         i_clk = 1'b0, i_sys_rst = 1'b1;
  reg         stb = 1'b0, ms = 1'b0, x1 = 1'b0, tl = 1'b0, ps = 1'b0, pa = 1'b0;
  reg         nb = 1'b0, nv = 1'b0;
  reg  [18:0] tow_i = 19'h0;
  reg  [12:0] wk_i = 13'h0, sv_i = 13'h0, sv_q = 13'h0, ad_i = 13'h0, ad_q = 13'h0;
  wire        rdy, ci, cq, cv, ss, pe, busy, ur, msg;
  wire [18:0] week_seconds_count;
  wire [12:0] wk;
  wire [16:0] mtow;
  wire [15:0] nch, nsym;
  reg  [12:0] xa, xi, xq, st_i, st_q;
  reg  [6:0]  hist;
  reg         qb[$];
  integer     pc, pos, nbit = 0, failures = 0, n_tests = 0;

  l5g_code_gen #(.WEEK_W(13)) l5g_code_gen_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_stb(stb), .i_ms_epoch(ms),
    .i_x1_epoch(x1), .i_time_load(tl), .i_tow_init(tow_i), .i_week_init(wk_i),
    .i_prep_stb(ps), .i_prep_advance(pa), .i_start_vec_i(sv_i), .i_start_vec_q(sv_q),
    .i_adv_i(ad_i), .i_adv_q(ad_q), .i_nav_bit(nb), .i_nav_valid(nv), .o_nav_ready(rdy),
    .o_inphase_spread_code(ci), .o_quadrature_spread_code(cq), .o_chip_valid(cv),
    .o_symbol_start(ss), .o_primary_epoch(pe), .o_prep_busy(busy), .o_nav_underrun(ur),
    .o_msg_start(msg), .o_tow_count(week_seconds_count), .o_week_num(wk), .o_msg_tow(mtow));
  l5g_rx_replica l5g_rx_replica_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_chip_valid(cv), .i_sym_start(ss), .o_n_chip(nch), .o_n_sym(nsym));

  initial
  begin
    forever #25 i_clk = ~i_clk;
  end
  // ==========================================================
  // Shared helpers
  function [12:0] step(input [12:0] s, input [12:0] t);
    step = {s[11:0], ^(s & t)};
  endfunction
  function [12:0] rev(input [12:0] v);
    integer k;
    for (k = 0; k < 13; k = k + 1) rev[k] = v[12-k];
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares=%0d mismatches=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // One chip strobe, reference replica update, then compare both lanes
  task chip(input m, input x);
    reg s, sym, u;
    begin
      stb = 1'b1; ms = m; x1 = x;
      @(posedge i_clk);
      u = 1'b0;
      if (m)
      begin
        xa = `L5G_ONES; pc = 0; xi = st_i; xq = st_q;
        pos = (x || pos == 19) ? 0 : pos + 1;
        if (pos == 0)
        begin
          u = (qb.size() == 0);
          s = u ? 1'b0 : qb.pop_front();
          hist = {s, hist[6:1]};
        end
      end
      else
      begin
        pc = (pc == 8189) ? 0 : pc + 1;
        xa = (pc == 0) ? `L5G_ONES : step(xa, `L5G_PRI_TAPS);
        xi = step(xi, `L5G_SEC_TAPS);
        xq = step(xq, `L5G_SEC_TAPS);
      end
      sym = (pos < 10) ? ^(hist & `L5G_G1_POLY) : ^(hist & `L5G_G2_POLY);
      #1 stb = 1'b0; ms = 1'b0; x1 = 1'b0;
      check(ur, u);
      @(posedge i_clk) #1;
      check(cv, 1);
      check(pe, pc == 0);
      check(ss, m && pos % 10 == 0);
      check(cq, xa[12] ^ xq[12] ^ NH20[19-pos]);
      check(ci, xa[12] ^ xi[12] ^ sym ^ NH10[9-pos%10]);
    end
  endtask
  task push(input b);
    integer k;
    reg r;
    begin
      nv = 1'b1; nb = b; r = 1'b0;
      for (k = 0; k < 100 && !r; k = k + 1)
      begin
        r = rdy;
        @(posedge i_clk);
      end
      if (!r)
      begin
        check(0, 1);
        tally_and_finish;
      end
      qb.push_back(b);
      #1 nv = 1'b0;
      @(posedge i_clk) #1;
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_prep(input adv, input [12:0] vi, input [12:0] vq);
    integer k;
    begin
      pa = adv; sv_i = vi; sv_q = vq; ad_i = vi; ad_q = vq; ps = 1'b1;
      @(posedge i_clk) #1 ps = 1'b0;
      st_i = rev(vi);
      st_q = rev(vq);
      if (adv)
      begin
        st_i = `L5G_ONES;
        st_q = `L5G_ONES;
        for (k = 0; k < vi; k = k + 1) st_i = step(st_i, `L5G_SEC_TAPS);
        for (k = 0; k < vq; k = k + 1) st_q = step(st_q, `L5G_SEC_TAPS);
        for (k = 0; k < 20 && busy !== 1'b1; k = k + 1) @(posedge i_clk) #1;
        check(busy, 1);
        for (k = 0; k < 100 && busy !== 1'b0; k = k + 1) @(posedge i_clk) #1;
        check(busy, 0);
        if (busy !== 1'b0)
          tally_and_finish;
      end
    end
  endtask
  task t_buffer;
    begin
      push(1'b1);
      push(1'b0);
      @(posedge i_clk) #1;
      check(rdy, 0);
    end
  endtask
  task t_stream(input integer n, input fill);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1)
      begin
        chip(1'b1, 1'b0);
        chip(1'b0, 1'b0);
        chip(1'b0, 1'b0);
        while (fill && qb.size() < 2)
        begin
          push(nbit[0] ^ nbit[2]);
          nbit = nbit + 1;
        end
      end
    end
  endtask
  task t_time(input [18:0] t0, input [18:0] t1, input [16:0] m1, input [12:0] w1);
    begin
      tow_i = t0; wk_i = 13'h5; tl = 1'b1;
      @(posedge i_clk) #1 tl = 1'b0;
      chip(1'b1, 1'b1);
      check(week_seconds_count, t1);
      check(mtow, m1);
      check(wk, w1);
    end
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    xa = `L5G_ONES; xi = xa; xq = xa; st_i = xa; st_q = xa; pc = 0; pos = 19; hist = 7'h0;
    repeat (6) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    check(week_seconds_count, 0);
    check(mtow, 0);
    t_prep(1'b0, 13'h0a5b, 13'h1234);
    t_buffer;
    t_stream(60, 1'b0);
    t_stream(40, 1'b1);
    t_time(19'h3, 19'h4, 17'h2, 13'h5);
    t_time(`L5G_TOW_LAST, 19'h0, 17'h1, 13'h6);
    t_prep(1'b1, 13'h5, 13'h2);
    chip(1'b1, 1'b0);
    repeat (10229) chip(1'b0, 1'b0);
    chip(1'b1, 1'b0);
    @(posedge i_clk) #1;
    check(nsym, 16'h000c);
    check(nch, 16'h2925);
    tally_and_finish;
  end
endmodule
